/* hdl/ddg_pkg.sv */
// package: register map and field layout for loop damping and gain configuration
package ddg_pkg;
  // register indices; the apb byte address is four times the index
  localparam logic [7:0] AUX_DAMP_IDX     = 8'h6A;
  localparam logic [7:0] OUT_DAMP_IDX     = 8'h6B;
  localparam logic [7:0] AUX_GAIN_EN_IDX  = 8'h6C;
  localparam logic [7:0] OUT_GAIN_EN_IDX  = 8'h6D;
  localparam logic [9:0] AUX_DAMP_ADDR    = {AUX_DAMP_IDX, 2'b00};
  localparam logic [9:0] OUT_DAMP_ADDR    = {OUT_DAMP_IDX, 2'b00};
  localparam logic [9:0] AUX_GAIN_EN_ADDR = {AUX_GAIN_EN_IDX, 2'b00};
  localparam logic [9:0] OUT_GAIN_EN_ADDR = {OUT_GAIN_EN_IDX, 2'b00};
  // field layout
  localparam int DAMP_LSB = 0;
  localparam int DAMP_MSB = 2;
  localparam int GAIN_LSB = 4;
  localparam int GAIN_MSB = 6;
  localparam int EN_BIT   = 7;
  // writable bits of a damping register: 7 and 3 are unused
  localparam logic [7:0] DAMP_WMASK = 8'h77;
  // reset values
  localparam logic [7:0] AUX_DAMP_RST = 8'h13;
  localparam logic [7:0] OUT_DAMP_RST = 8'h13;
  localparam logic [7:0] GAIN_EN_RST  = 8'h00;
  // damping codes
  localparam logic [2:0] DAMP_MIN     = 3'h1;
  localparam logic [2:0] DAMP_MAX     = 3'h5;
  localparam logic [2:0] DAMP_DEFAULT = 3'h3;
endpackage

/* hdl/ddg_loop_cfg.sv */
// one loop's damping register with gated low-rate gain output
`timescale 1ns/1ps
`default_nettype none
module ddg_loop_cfg
  import ddg_pkg::*;
#(
  parameter logic [7:0] RST_VAL = 8'h13
) (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       wr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       gain_en_in,
  output logic [7:0]      reg_out,
  output logic [2:0]      damp_out,
  output logic [2:0]      gain_out,
  output logic            gain_valid_out
);
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  logic [2:0] damp_reg;
  logic [2:0] damp_next;
  logic [2:0] gain_reg;
  logic [2:0] gain_next;
  logic       gv_reg;
  logic       gv_next;

  // a reset value with unused bits or an unused code would disagree with the loop outputs
  if ((RST_VAL & ~DAMP_WMASK) != 8'h00 || RST_VAL[DAMP_MSB:DAMP_LSB] < DAMP_MIN ||
      RST_VAL[DAMP_MSB:DAMP_LSB] > DAMP_MAX) begin : g_bad_rst_val
    $error("reset value not usable for a damping register");
  end

  // next values; unused bits never store, so they read zero
  always_comb begin
    cfg_next = cfg_reg;
    if (wr_in) begin
      cfg_next = wdata_in & DAMP_WMASK;
    end
    damp_next = cfg_reg[DAMP_MSB:DAMP_LSB];
    // unused codes stay in the register only; loop falls back to default code
    if (cfg_reg[DAMP_MSB:DAMP_LSB] < DAMP_MIN || cfg_reg[DAMP_MSB:DAMP_LSB] > DAMP_MAX) begin
      damp_next = DAMP_DEFAULT;
    end
    gv_next   = gain_en_in;
    gain_next = gain_en_in ? cfg_reg[GAIN_MSB:GAIN_LSB] : 3'h0;
  end

  // registers; outputs come from flops to keep timing clean into the loop
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_reg  <= RST_VAL;
      damp_reg <= RST_VAL[DAMP_MSB:DAMP_LSB];
      gain_reg <= 3'h0;
      gv_reg   <= 1'b0;
    end else begin
      cfg_reg  <= cfg_next;
      damp_reg <= damp_next;
      gain_reg <= gain_next;
      gv_reg   <= gv_next;
    end
  end

  assign reg_out        = cfg_reg;
  assign damp_out       = damp_reg;
  assign gain_out       = gain_reg;
  assign gain_valid_out = gv_reg;
endmodule
`default_nettype wire

/* hdl/ddg_top.sv */
// apb register bank for loop damping and low-rate analog gain configuration
// How it works
// - aux loop damping register, read/write, resets 0x13
// - damping codes 001..101 valid, others unused
// - damping resets to code 011
// - output loop damping register, same encoding
// - bits 6..4 set low-rate analog gain
// - output gain used only when 6D bit7
// - aux gain used only when 6C bit7
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module ddg_top
  import ddg_pkg::*;
(
  // clock and reset
  input  wire logic       CLK_IN,
  input  wire logic       RST_N_IN,
  // apb slave
  input  wire logic       PSEL_IN,
  input  wire logic       PENABLE_IN,
  input  wire logic       PWRITE_IN,
  input  wire logic [9:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  input  wire logic [3:0] PSTRB_IN,
  output logic [31:0]     PRDATA_OUT,
  output logic            PREADY_OUT,
  output logic            PSLVERR_OUT,
  // transmit output loop
  output logic [2:0]      OUTPUT_LOOP_DAMPING_SEL_OUT,
  output logic [2:0]      OUTPUT_LOWRATE_ANALOG_GAIN_OUT,
  output logic            OUTPUT_GAIN_ACTIVE_OUT,
  // auxiliary loop
  output logic [2:0]      AUX_LOOP_DAMPING_SEL_OUT,
  output logic [2:0]      AUX_LOWRATE_ANALOG_GAIN_OUT,
  output logic            AUX_GAIN_ACTIVE_OUT
);
  logic        setup;
  logic        access;
  logic        wr_commit;
  logic        wr_aux_damp;
  logic        wr_out_damp;
  logic        wr_aux_en;
  logic        wr_out_en;
  logic [7:0]  aux_reg_val;
  logic [7:0]  out_reg_val;
  logic [7:0]  aux_en_reg;
  logic [7:0]  aux_en_next;
  logic [7:0]  out_en_reg;
  logic [7:0]  out_en_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        ready_reg;
  logic        ready_next;
  logic        err_reg;
  logic        err_next;

  // address decode, used by both write and read paths
  function automatic logic hit(input logic [9:0] a, input logic [9:0] base);
    return a == base;
  endfunction

  function automatic logic mapped(input logic [9:0] a);
    return hit(a, AUX_DAMP_ADDR) || hit(a, OUT_DAMP_ADDR) || hit(a, AUX_GAIN_EN_ADDR) || hit(a, OUT_GAIN_EN_ADDR);
  endfunction

  // no wait state: answer in the first access cycle after setup
  assign setup  = PSEL_IN && !PENABLE_IN;
  // a write lands only at the edge that completes the access, never at setup
  assign access    = PSEL_IN && PENABLE_IN && ready_reg;
  assign wr_commit = access && PWRITE_IN && PSTRB_IN[0];

  // per-register write strobes; unmapped words match none, so nothing is written
  assign wr_aux_damp = wr_commit && hit(PADDR_IN, AUX_DAMP_ADDR);
  assign wr_out_damp = wr_commit && hit(PADDR_IN, OUT_DAMP_ADDR);
  assign wr_aux_en   = wr_commit && hit(PADDR_IN, AUX_GAIN_EN_ADDR);
  assign wr_out_en   = wr_commit && hit(PADDR_IN, OUT_GAIN_EN_ADDR);

  // gain enable registers; only bit 7 is kept, others read zero
  always_comb begin
    aux_en_next = aux_en_reg;
    out_en_next = out_en_reg;
    if (wr_aux_en) begin
      aux_en_next = {PWDATA_IN[EN_BIT], 7'h00};
    end
    if (wr_out_en) begin
      out_en_next = {PWDATA_IN[EN_BIT], 7'h00};
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      aux_en_reg <= GAIN_EN_RST;
      out_en_reg <= GAIN_EN_RST;
    end else begin
      aux_en_reg <= aux_en_next;
      out_en_reg <= out_en_next;
    end
  end

  // the two damping registers share one layout
  ddg_loop_cfg #(
    .RST_VAL (AUX_DAMP_RST)
  ) u_aux (
    .clk_in         (CLK_IN),
    .rst_n_in       (RST_N_IN),
    .wr_in          (wr_aux_damp),
    .wdata_in       (PWDATA_IN[7:0]),
    .gain_en_in     (aux_en_reg[EN_BIT]),
    .reg_out        (aux_reg_val),
    .damp_out       (AUX_LOOP_DAMPING_SEL_OUT),
    .gain_out       (AUX_LOWRATE_ANALOG_GAIN_OUT),
    .gain_valid_out (AUX_GAIN_ACTIVE_OUT)
  );

  ddg_loop_cfg #(
    .RST_VAL (OUT_DAMP_RST)
  ) u_out (
    .clk_in         (CLK_IN),
    .rst_n_in       (RST_N_IN),
    .wr_in          (wr_out_damp),
    .wdata_in       (PWDATA_IN[7:0]),
    .gain_en_in     (out_en_reg[EN_BIT]),
    .reg_out        (out_reg_val),
    .damp_out       (OUTPUT_LOOP_DAMPING_SEL_OUT),
    .gain_out       (OUTPUT_LOWRATE_ANALOG_GAIN_OUT),
    .gain_valid_out (OUTPUT_GAIN_ACTIVE_OUT)
  );

  // bus answer; read data captured at setup, valid with pready
  always_comb begin
    ready_next = setup;
    err_next   = setup && !mapped(PADDR_IN);
    rdata_next = 32'h0000_0000;
    if (setup && !PWRITE_IN) begin
      unique case (1'b1)
        hit(PADDR_IN, AUX_DAMP_ADDR):    rdata_next = {24'h00_0000, aux_reg_val};
        hit(PADDR_IN, OUT_DAMP_ADDR):    rdata_next = {24'h00_0000, out_reg_val};
        hit(PADDR_IN, AUX_GAIN_EN_ADDR): rdata_next = {24'h00_0000, aux_en_reg};
        hit(PADDR_IN, OUT_GAIN_EN_ADDR): rdata_next = {24'h00_0000, out_en_reg};
        default:                         rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rdata_reg <= 32'h0000_0000;
      ready_reg <= 1'b0;
      err_reg   <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      ready_reg <= ready_next;
      err_reg   <= err_next;
    end
  end

  assign PRDATA_OUT  = rdata_reg;
  assign PREADY_OUT  = ready_reg;
  assign PSLVERR_OUT = err_reg;
endmodule
`default_nettype wire

/* test/ddg_top_asserts.sv */
// port assertions for the damping and gain register bank
`timescale 1ns/1ps
`default_nettype none
module ddg_top_chk
  import ddg_pkg::*;
(
  // apb side
  input wire logic        CLK_IN,
  input wire logic        RST_N_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [9:0]  PADDR_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic        PREADY_OUT,
  input wire logic        PSLVERR_OUT,
  // loop side
  input wire logic [2:0]  OUTPUT_LOOP_DAMPING_SEL_OUT,
  input wire logic [2:0]  OUTPUT_LOWRATE_ANALOG_GAIN_OUT,
  input wire logic        OUTPUT_GAIN_ACTIVE_OUT,
  input wire logic [2:0]  AUX_LOOP_DAMPING_SEL_OUT,
  input wire logic [2:0]  AUX_LOWRATE_ANALOG_GAIN_OUT,
  input wire logic        AUX_GAIN_ACTIVE_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // decoded setup phase and address classes
  wire logic setup  = PSEL_IN && !PENABLE_IN;
  wire logic dmp    = PADDR_IN == AUX_DAMP_ADDR || PADDR_IN == OUT_DAMP_ADDR;
  wire logic mapped = dmp || PADDR_IN == AUX_GAIN_EN_ADDR || PADDR_IN == OUT_GAIN_EN_ADDR;
  property p_rdy; setup |=> PREADY_OUT; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_err; setup && !mapped |=> PSLVERR_OUT && PRDATA_OUT == 32'h0; endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_zero; setup && dmp && !PWRITE_IN |=> PRDATA_OUT[31:7] == 25'h0 && !PRDATA_OUT[3]; endproperty
  a_zero: assert property (p_zero) else $error("unused damping bits set");
  property p_ad; AUX_LOOP_DAMPING_SEL_OUT inside {[3'h1:3'h5]}; endproperty
  a_ad: assert property (p_ad) else $error("aux damping code unused");
  property p_od; OUTPUT_LOOP_DAMPING_SEL_OUT inside {[3'h1:3'h5]}; endproperty
  a_od: assert property (p_od) else $error("output damping code unused");
  // first edge after reset must show the default code on both loops
  property p_rst; $rose(RST_N_IN) |-> AUX_LOOP_DAMPING_SEL_OUT == DAMP_DEFAULT
    && OUTPUT_LOOP_DAMPING_SEL_OUT == DAMP_DEFAULT; endproperty
  a_rst: assert property (p_rst) else $error("damping not default after reset");
  property p_ag; !AUX_GAIN_ACTIVE_OUT |-> AUX_LOWRATE_ANALOG_GAIN_OUT == 3'h0; endproperty
  a_ag: assert property (p_ag) else $error("aux gain used while disabled");
  property p_og; !OUTPUT_GAIN_ACTIVE_OUT |-> OUTPUT_LOWRATE_ANALOG_GAIN_OUT == 3'h0; endproperty
  a_og: assert property (p_og) else $error("output gain used while disabled");
endmodule
bind ddg_top ddg_top_chk u_chk (
  .CLK_IN                         (CLK_IN),
  .RST_N_IN                       (RST_N_IN),
  .PSEL_IN                        (PSEL_IN),
  .PENABLE_IN                     (PENABLE_IN),
  .PWRITE_IN                      (PWRITE_IN),
  .PADDR_IN                       (PADDR_IN),
  .PRDATA_OUT                     (PRDATA_OUT),
  .PREADY_OUT                     (PREADY_OUT),
  .PSLVERR_OUT                    (PSLVERR_OUT),
  .OUTPUT_LOOP_DAMPING_SEL_OUT    (OUTPUT_LOOP_DAMPING_SEL_OUT),
  .OUTPUT_LOWRATE_ANALOG_GAIN_OUT (OUTPUT_LOWRATE_ANALOG_GAIN_OUT),
  .OUTPUT_GAIN_ACTIVE_OUT         (OUTPUT_GAIN_ACTIVE_OUT),
  .AUX_LOOP_DAMPING_SEL_OUT       (AUX_LOOP_DAMPING_SEL_OUT),
  .AUX_LOWRATE_ANALOG_GAIN_OUT    (AUX_LOWRATE_ANALOG_GAIN_OUT),
  .AUX_GAIN_ACTIVE_OUT            (AUX_GAIN_ACTIVE_OUT)
);
`default_nettype wire

/* test/test_ddg_top.sv */
// self-checking bench for the damping and gain register bank
`timescale 1ns/1ps
`default_nettype none
module test_ddg_top
  import ddg_pkg::*;
;
  logic        CLK_IN = 1'b0, RST_N_IN = 1'b0, PSEL_IN = 1'b0, PENABLE_IN = 1'b0, PWRITE_IN = 1'b0;
  logic [9:0]  PADDR_IN = 10'h000;
  logic [3:0]  PSTRB_IN = 4'hF;
  logic [31:0] PWDATA_IN = 32'h0, PRDATA_OUT, rd;
  logic        PREADY_OUT, PSLVERR_OUT, OUTPUT_GAIN_ACTIVE_OUT, AUX_GAIN_ACTIVE_OUT, er;
  logic [2:0]  OUTPUT_LOOP_DAMPING_SEL_OUT, OUTPUT_LOWRATE_ANALOG_GAIN_OUT, v, e;
  logic [2:0]  AUX_LOOP_DAMPING_SEL_OUT, AUX_LOWRATE_ANALOG_GAIN_OUT;
  int          err_count = 0, tests_run = 0;
  ddg_top u_ddg_top (
    .CLK_IN                         (CLK_IN),
    .RST_N_IN                       (RST_N_IN),
    .PSEL_IN                        (PSEL_IN),
    .PENABLE_IN                     (PENABLE_IN),
    .PWRITE_IN                      (PWRITE_IN),
    .PADDR_IN                       (PADDR_IN),
    .PWDATA_IN                      (PWDATA_IN),
    .PSTRB_IN                       (PSTRB_IN),
    .PRDATA_OUT                     (PRDATA_OUT),
    .PREADY_OUT                     (PREADY_OUT),
    .PSLVERR_OUT                    (PSLVERR_OUT),
    .OUTPUT_LOOP_DAMPING_SEL_OUT    (OUTPUT_LOOP_DAMPING_SEL_OUT),
    .OUTPUT_LOWRATE_ANALOG_GAIN_OUT (OUTPUT_LOWRATE_ANALOG_GAIN_OUT),
    .OUTPUT_GAIN_ACTIVE_OUT         (OUTPUT_GAIN_ACTIVE_OUT),
    .AUX_LOOP_DAMPING_SEL_OUT       (AUX_LOOP_DAMPING_SEL_OUT),
    .AUX_LOWRATE_ANALOG_GAIN_OUT    (AUX_LOWRATE_ANALOG_GAIN_OUT),
    .AUX_GAIN_ACTIVE_OUT            (AUX_GAIN_ACTIVE_OUT)
  );
  initial begin
    forever #2 CLK_IN = ~CLK_IN;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // psel stays up so transfers run back to back; idle drops it
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    PSEL_IN <= 1'b1;
    PWRITE_IN <= w;
    PADDR_IN <= a;
    PWDATA_IN <= d;
    PSTRB_IN <= s;
    @(posedge CLK_IN);
    PENABLE_IN <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK_IN);
      n++;
    end while (PREADY_OUT !== 1'b1 && n < 20);
    rd = PRDATA_OUT;
    er = PSLVERR_OUT;
    PENABLE_IN <= 1'b0;
    if (PREADY_OUT !== 1'b1) begin
      err_count++;
      test_done;
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask
  task automatic rdx(input logic [9:0] a, input logic [31:0] x, input logic xe);
    xfer(1'b0, a, 32'h0, 4'hF);
    chk(rd, x);
    chk(32'(er), 32'(xe));
  endtask
  // two edges let the loop outputs follow the last write
  task automatic idle;
    PSEL_IN <= 1'b0;
    repeat (2) @(posedge CLK_IN);
  endtask
  initial begin
    repeat (6) @(posedge CLK_IN);
    RST_N_IN <= 1'b1;
    rdx(AUX_DAMP_ADDR, 32'h13, 1'b0);
    rdx(OUT_DAMP_ADDR, 32'h13, 1'b0);
    idle;
    chk(32'({AUX_LOOP_DAMPING_SEL_OUT, OUTPUT_LOOP_DAMPING_SEL_OUT}), 32'h1B);
    // every damping code on both loops, unused bits forced high
    for (int c = 0; c < 8; c++) begin
      v = c[2:0];
      e = (v >= DAMP_MIN && v <= DAMP_MAX) ? v : 3'h3;
      wr(AUX_DAMP_ADDR, {24'hFFFFFF, 1'b1, v, 1'b1, v});
      wr(OUT_DAMP_ADDR, {24'hFFFFFF, 1'b1, v, 1'b1, v});
      rdx(AUX_DAMP_ADDR, {25'h0, v, 1'b0, v}, 1'b0);
      rdx(OUT_DAMP_ADDR, {25'h0, v, 1'b0, v}, 1'b0);
      idle;
      chk(32'({AUX_LOOP_DAMPING_SEL_OUT, OUTPUT_LOOP_DAMPING_SEL_OUT}), 32'({e, e}));
      chk(32'({AUX_LOWRATE_ANALOG_GAIN_OUT, OUTPUT_LOWRATE_ANALOG_GAIN_OUT}), 32'h00);
    end
    wr(AUX_GAIN_EN_ADDR, 32'hFF);
    wr(OUT_GAIN_EN_ADDR, 32'h80);
    rdx(AUX_GAIN_EN_ADDR, 32'h80, 1'b0);
    rdx(OUT_GAIN_EN_ADDR, 32'h80, 1'b0);
    wr(AUX_DAMP_ADDR, 32'h52);
    wr(OUT_DAMP_ADDR, 32'h64);
    xfer(1'b1, OUT_DAMP_ADDR, 32'h11, 4'hE);
    rdx(OUT_DAMP_ADDR, 32'h64, 1'b0);
    idle;
    chk(32'({AUX_GAIN_ACTIVE_OUT, AUX_LOWRATE_ANALOG_GAIN_OUT, AUX_LOOP_DAMPING_SEL_OUT}), 32'h6A);
    chk(32'({OUTPUT_GAIN_ACTIVE_OUT, OUTPUT_LOWRATE_ANALOG_GAIN_OUT, OUTPUT_LOOP_DAMPING_SEL_OUT}), 32'h74);
    wr(AUX_GAIN_EN_ADDR, 32'h0);
    wr(10'h3FC, 32'hFF);
    chk(32'(er), 32'h1);
    rdx(10'h3FC, 32'h0, 1'b1);
    idle;
    chk(32'({AUX_GAIN_ACTIVE_OUT, AUX_LOWRATE_ANALOG_GAIN_OUT, AUX_LOOP_DAMPING_SEL_OUT}), 32'h02);
    chk(32'({OUTPUT_GAIN_ACTIVE_OUT, OUTPUT_LOWRATE_ANALOG_GAIN_OUT}), 32'hE);
    // reset in mid-run must bring both damping registers, the output gain enable and every loop output back to default
    RST_N_IN <= 1'b0;
    repeat (2) @(posedge CLK_IN);
    RST_N_IN <= 1'b1;
    rdx(AUX_DAMP_ADDR, 32'h13, 1'b0);
    rdx(OUT_DAMP_ADDR, 32'h13, 1'b0);
    rdx(OUT_GAIN_EN_ADDR, 32'h0, 1'b0);
    idle;
    chk(32'({AUX_GAIN_ACTIVE_OUT, AUX_LOWRATE_ANALOG_GAIN_OUT, AUX_LOOP_DAMPING_SEL_OUT}), 32'h03);
    chk(32'({OUTPUT_GAIN_ACTIVE_OUT, OUTPUT_LOWRATE_ANALOG_GAIN_OUT, OUTPUT_LOOP_DAMPING_SEL_OUT}), 32'h03);
    test_done;
  end
endmodule
`default_nettype wire
